// file: mppi_pkg.sv
package mppi_pkg;
  // Pixel port geometry
  localparam int SLOT_MAX  = 4;
  localparam int WORD_W    = 24;
  localparam int DATA_W    = 96;
  localparam int CODE_W    = 10;
  localparam int PAL_AW    = 8;
  localparam int PAL_DW    = 30;
  // Multiplex rate codes
  localparam logic [1:0] MUX_2TO1 = 2'h0;
  localparam logic [1:0] MUX_4TO1 = 2'h1;
  localparam logic [1:0] MUX_8TO1 = 2'h2;
  // Pixel format codes (low bits of palette and bypass color modes)
  localparam logic [1:0] FMT_TRUE24 = 2'h0;
  localparam logic [1:0] FMT_TRUE16 = 2'h1;
  localparam logic [1:0] FMT_TRUE15 = 2'h2;
  localparam logic [1:0] FMT_PSEUDO = 2'h3;
  // Priority select function codes
  localparam logic [1:0] FN_PALETTE = 2'h0;
  localparam logic [1:0] FN_BYPASS  = 2'h1;
  localparam logic [1:0] FN_OVERLAY = 2'h2;
  localparam logic [1:0] FN_IGNORE  = 2'h3;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_PAL_ADDR = 8'h08;
  localparam logic [7:0] REG_PAL_DATA = 8'h0C;
  localparam logic [7:0] REG_OVL1     = 8'h10;
  localparam logic [7:0] REG_OVL2     = 8'h14;
  localparam logic [7:0] REG_OVL3     = 8'h18;
  // Control register fields
  localparam int CTRL_MUX   = 0;
  localparam int CTRL_GSE   = 4;
  localparam int CTRL_RSE   = 5;
  localparam int CTRL_BSE   = 6;
  localparam int CTRL_TSE   = 7;
  localparam int CTRL_FN    = 8;
  localparam int CTRL_MATCH = 10;
  localparam int CTRL_PCM   = 12;
  localparam int CTRL_BCM   = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0003_FFF3;
  // Analog output level per channel
  typedef enum logic [2:0] {LVL_VIDEO, LVL_BLANK, LVL_SYNC, LVL_TRI, LVL_OFF} mppi_level_t;
endpackage

// file: mppi_sync2.sv
`timescale 1ns/100ps
module mppi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages; only the second stage is seen by any logic
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule

// file: mppi_palette.sv
`timescale 1ns/100ps
module mppi_palette import mppi_pkg::*; #(
  parameter int AW = PAL_AW
) (
  input  wire logic              mclk,
  input  wire logic              we,
  input  wire logic [AW-1:0]     waddr,
  input  wire logic [PAL_DW-1:0] wdata,
  input  wire logic [AW-1:0]     ra_red,
  input  wire logic [AW-1:0]     ra_green,
  input  wire logic [AW-1:0]     ra_blue,
  output logic      [CODE_W-1:0] rd_red,
  output logic      [CODE_W-1:0] rd_green,
  output logic      [CODE_W-1:0] rd_blue
);
  logic [PAL_DW-1:0] mem [0:(1<<AW)-1];

  // One write port, three registered read ports, one per channel
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rd_red   <= mem[ra_red][29:20];
    rd_green <= mem[ra_green][19:10];
    rd_blue  <= mem[ra_blue][9:0];
  end
endmodule

// file: mppi_port.sv
`timescale 1ns/100ps
// Summary of operation
// - 96 inputs as four 24-bit slot words
// - True color 4:1/2:1, pseudo 8:1/4:1/2:1
// - Capture color on strobe rising edge
// - Controls and selects captured with color
// - Pipeline on pixel clock, strobe phase free
// - Output strobe matches multiplex rate
// - Blank and sync force their levels
// - Per channel sync enable bits
// - All enables off ignores sync on channel outputs
// - Separate sync out with pipeline delay
// - Three level sync on enabled channels
// - Function field picks select meaning
// - Selects demultiplexed like color data
// - 8:1 pseudo: blue gives extra selects
// - Palette match else outputs off
// - Bypass control per pixel in 4:1/2:1
// - Overlay color on nonzero select
// - Palette or bypass per pixel in 4:1/2:1
// - 256 by 30 palette feeds converters
module mppi_port import mppi_pkg::*; (
  input  wire logic               mclk,
  input  wire logic               srst,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [DATA_W-1:0]  color_data,
  input  wire logic               sync_n,
  input  wire logic               blank_n,
  input  wire logic               three_level_sync_n,
  input  wire logic [3:0]         priority_select_bit0,
  input  wire logic [3:0]         priority_select_bit1,
  input  wire logic               pixel_latch_strobe,
  output logic                    generated_latch_strobe,
  output logic                    separate_sync_output_n,
  output logic      [CODE_W-1:0]  red_code,
  output logic      [CODE_W-1:0]  green_code,
  output logic      [CODE_W-1:0]  blue_code,
  output mppi_level_t             red_level,
  output mppi_level_t             green_level,
  output mppi_level_t             blue_level,
  output logic                    pixel_valid
);
  localparam int IN_W = DATA_W + 12;

  // Pixel format to three palette indices
  function automatic logic [23:0] fmt_decode(input logic [23:0] w, input logic [1:0] f);
    case (f)
      FMT_TRUE24: fmt_decode = w;
      FMT_TRUE16: fmt_decode = {w[15:11], w[15:13], w[10:5], w[10:9], w[4:0], w[4:2]};
      FMT_TRUE15: fmt_decode = {w[14:10], w[14:12], w[9:5], w[9:7], w[4:0], w[4:2]};
      default:    fmt_decode = {w[7:0], w[7:0], w[7:0]};
    endcase
  endfunction

  // Channel level: shutdown first, then tri-sync, sync, blank
  function automatic mppi_level_t lvl(input logic off, input logic sen, input logic tse,
                                      input logic tri_a, input logic syn, input logic blk);
    if (off) lvl = LVL_OFF;
    else if (sen && tse && tri_a) lvl = LVL_TRI;
    else if (sen && syn) lvl = LVL_SYNC;
    else if (blk) lvl = LVL_BLANK;
    else lvl = LVL_VIDEO;
  endfunction

  // Pin inputs pass two flip-flops, strobe aligned with its data
  logic [IN_W-1:0] s_bus;
  mppi_sync2 #(.W(IN_W)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .din  ({pixel_latch_strobe, three_level_sync_n, blank_n, sync_n,
            priority_select_bit1, priority_select_bit0, color_data}),
    .dout (s_bus)
  );

  // Register file state
  logic [31:0]       ctrl_ff, nxt_ctrl;
  logic [7:0]        pal_addr_ff, nxt_pal_addr;
  logic [PAL_DW-1:0] ovl_ff [0:2];
  logic [PAL_DW-1:0] nxt_ovl [0:2];
  logic              ack_ff, nxt_ack;
  logic [31:0]       rdat_ff, nxt_rdat;
  logic [15:0]       cap_cnt_ff, nxt_cap_cnt;
  logic              pal_we;
  logic [31:0]       wmask;
  logic [1:0]        mux;
  logic [1:0]        fn;
  logic              eight;

  assign mux   = ctrl_ff[CTRL_MUX +: 2];
  assign fn    = ctrl_ff[CTRL_FN +: 2];
  assign eight = (mux == MUX_8TO1);
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Capture and serializer state
  logic              strobe_d_ff, nxt_strobe_d;
  logic [IN_W-2:0]   cap_ff, nxt_cap;
  logic [2:0]        slot_ff, nxt_slot;
  logic              act_ff, nxt_act;
  logic              edge_det;
  logic [2:0]        last_slot;

  // Wishbone classic slave: ack one cycle after the strobe, dropped next cycle
  always_comb begin
    nxt_ctrl     = ctrl_ff;
    nxt_pal_addr = pal_addr_ff;
    nxt_ovl      = ovl_ff;
    nxt_ack      = 1'b0;
    nxt_rdat     = 32'h0000_0000;
    pal_we       = 1'b0;
    if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      nxt_ack = 1'b1;
      if (wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL:     nxt_ctrl = ((ctrl_ff & ~wmask) | (wb_dat_i & wmask)) & CTRL_MASK;
          REG_PAL_ADDR: if (wb_sel_i[0]) nxt_pal_addr = wb_dat_i[7:0];
          REG_PAL_DATA: begin // Auto-increment eases loading all 256 entries
            pal_we       = 1'b1;
            nxt_pal_addr = pal_addr_ff + 8'h01;
          end
          REG_OVL1:     nxt_ovl[0] = wb_dat_i[PAL_DW-1:0];
          REG_OVL2:     nxt_ovl[1] = wb_dat_i[PAL_DW-1:0];
          REG_OVL3:     nxt_ovl[2] = wb_dat_i[PAL_DW-1:0];
          default:      ;
        endcase
      end else begin
        case (wb_adr_i)
          REG_CTRL:     nxt_rdat = ctrl_ff;
          REG_STATUS:   nxt_rdat = {cap_cnt_ff, 11'h000, act_ff, 1'b0, slot_ff};
          REG_PAL_ADDR: nxt_rdat = {24'h00_0000, pal_addr_ff};
          REG_OVL1:     nxt_rdat = {2'h0, ovl_ff[0]};
          REG_OVL2:     nxt_rdat = {2'h0, ovl_ff[1]};
          REG_OVL3:     nxt_rdat = {2'h0, ovl_ff[2]};
          default:      nxt_rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_ff     <= CTRL_RST;
      pal_addr_ff <= 8'h00;
      ovl_ff      <= '{default: '0};
      ack_ff      <= 1'b0;
      rdat_ff     <= 32'h0000_0000;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      pal_addr_ff <= nxt_pal_addr;
      ovl_ff      <= nxt_ovl;
      ack_ff      <= nxt_ack;
      rdat_ff     <= nxt_rdat;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // Strobe edge loads all inputs at once and restarts slot A; the pixel clock steps the slots
  always_comb begin
    last_slot    = eight ? 3'h7 : ((mux == MUX_4TO1) ? 3'h3 : 3'h1);
    nxt_strobe_d = s_bus[IN_W-1];
    edge_det     = s_bus[IN_W-1] && !strobe_d_ff;
    nxt_cap      = cap_ff;
    nxt_slot     = slot_ff;
    nxt_act      = act_ff;
    nxt_cap_cnt  = cap_cnt_ff;
    if (edge_det) begin
      nxt_cap     = s_bus[IN_W-2:0];
      nxt_slot    = 3'h0;
      nxt_act     = 1'b1;
      nxt_cap_cnt = cap_cnt_ff + 16'h0001;
    end else if (act_ff) begin
      if (slot_ff == last_slot) nxt_act = 1'b0;
      else nxt_slot = slot_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      strobe_d_ff <= 1'b0;
      cap_ff      <= '0;
      slot_ff     <= 3'h0;
      act_ff      <= 1'b0;
      cap_cnt_ff  <= 16'h0000;
    end else begin
      strobe_d_ff <= nxt_strobe_d;
      cap_ff      <= nxt_cap;
      slot_ff     <= nxt_slot;
      act_ff      <= nxt_act;
      cap_cnt_ff  <= nxt_cap_cnt;
    end
  end

  // Slot demultiplex: word, select pair and controls of the current pixel
  logic [23:0] slot_word;
  logic [1:0]  slot_sel;
  logic [1:0]  k;
  logic [23:0] pix_ff, nxt_pix;
  logic [1:0]  sel_ff, nxt_sel;
  logic [2:0]  ctl_ff, nxt_ctl;
  logic        pv_ff, nxt_pv;
  always_comb begin
    k         = eight ? slot_ff[2:1] : slot_ff[1:0];
    slot_word = cap_ff[WORD_W*k +: WORD_W];
    slot_sel  = {cap_ff[DATA_W+4+k], cap_ff[DATA_W+k]};
    if (eight) begin
      // Odd pixels take their selects from the spare blue inputs
      slot_word = {16'h0000, slot_ff[0] ? slot_word[15:8] : slot_word[23:16]};
      if (slot_ff[0]) slot_sel = cap_ff[WORD_W*k +: 2];
    end
    nxt_pix = slot_word;
    nxt_sel = slot_sel;
    nxt_ctl = ~cap_ff[DATA_W+10:DATA_W+8]; // Active-high tri, blank, sync
    nxt_pv  = act_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pix_ff <= 24'h00_0000;
      sel_ff <= 2'h0;
      ctl_ff <= 3'h0;
      pv_ff  <= 1'b0;
    end else begin
      pix_ff <= nxt_pix;
      sel_ff <= nxt_sel;
      ctl_ff <= nxt_ctl;
      pv_ff  <= nxt_pv;
    end
  end

  // Per-pixel routing decision; palette read runs alongside
  logic [1:0]  pfmt, bfmt;
  logic [23:0] pidx, bidx;
  logic        byp_ff, nxt_byp, off_ff, nxt_off, v3_ff, nxt_v3;
  logic [1:0]  ovs_ff, nxt_ovs;
  logic [2:0]  c3_ff, nxt_c3;
  logic [23:0] bw_ff, nxt_bw;
  logic [9:0]  pr, pg, pb;
  always_comb begin
    pfmt    = eight ? FMT_PSEUDO : ctrl_ff[CTRL_PCM +: 2];
    bfmt    = eight ? FMT_PSEUDO : ctrl_ff[CTRL_BCM +: 2];
    pidx    = fmt_decode(pix_ff, pfmt);
    bidx    = fmt_decode(pix_ff, bfmt);
    nxt_byp = 1'b0;
    nxt_ovs = 2'h0;
    nxt_off = 1'b0;
    case (fn)
      FN_PALETTE: nxt_off = (sel_ff != ctrl_ff[CTRL_MATCH +: 2]);
      FN_BYPASS: begin
        // Bypass control is not offered with 8:1 pseudo color
        if (!eight && sel_ff[0]) nxt_ovs = 2'h1;
        else if (!eight) nxt_byp = sel_ff[1];
      end
      FN_OVERLAY: nxt_ovs = sel_ff;
      default: ;
    endcase
    nxt_bw = bidx;
    nxt_c3 = ctl_ff;
    nxt_v3 = pv_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      byp_ff <= 1'b0;
      off_ff <= 1'b0;
      v3_ff  <= 1'b0;
      ovs_ff <= 2'h0;
      c3_ff  <= 3'h0;
      bw_ff  <= 24'h00_0000;
    end else begin
      byp_ff <= nxt_byp;
      off_ff <= nxt_off;
      v3_ff  <= nxt_v3;
      ovs_ff <= nxt_ovs;
      c3_ff  <= nxt_c3;
      bw_ff  <= nxt_bw;
    end
  end

  mppi_palette #(.AW(PAL_AW)) u_pal (
    .mclk     (mclk),
    .we       (pal_we),
    .waddr    (pal_addr_ff),
    .wdata    (wb_dat_i[PAL_DW-1:0]),
    .ra_red   (pidx[23:16]),
    .ra_green (pidx[15:8]),
    .ra_blue  (pidx[7:0]),
    .rd_red   (pr),
    .rd_green (pg),
    .rd_blue  (pb)
  );

  // Final colour and levels; sync output rides the same stages
  logic [29:0] col;
  logic        gse, rse, bse, tse;
  logic [29:0] o_col_ff, nxt_col;
  mppi_level_t r_l_ff, g_l_ff, b_l_ff, nxt_rl, nxt_gl, nxt_bl;
  logic        so_ff, nxt_so, ov_ff, nxt_ov;
  always_comb begin
    gse = ctrl_ff[CTRL_GSE];
    rse = ctrl_ff[CTRL_RSE];
    bse = ctrl_ff[CTRL_BSE];
    tse = ctrl_ff[CTRL_TSE];
    if (ovs_ff != 2'h0) col = ovl_ff[ovs_ff - 2'h1];
    else if (byp_ff) col = {bw_ff[23:16], 2'h0, bw_ff[15:8], 2'h0, bw_ff[7:0], 2'h0};
    else col = {pr, pg, pb};
    nxt_rl  = lvl(off_ff, rse, tse, c3_ff[2], c3_ff[0], c3_ff[1]);
    nxt_gl  = lvl(off_ff, gse, tse, c3_ff[2], c3_ff[0], c3_ff[1]);
    nxt_bl  = lvl(off_ff, bse, tse, c3_ff[2], c3_ff[0], c3_ff[1]);
    nxt_col = (off_ff || !v3_ff) ? 30'h0000_0000 : col;
    nxt_so  = !(v3_ff && c3_ff[0]);
    nxt_ov  = v3_ff;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      o_col_ff <= 30'h0000_0000;
      r_l_ff   <= LVL_BLANK;
      g_l_ff   <= LVL_BLANK;
      b_l_ff   <= LVL_BLANK;
      so_ff    <= 1'b1;
      ov_ff    <= 1'b0;
    end else begin
      o_col_ff <= nxt_col;
      r_l_ff   <= nxt_rl;
      g_l_ff   <= nxt_gl;
      b_l_ff   <= nxt_bl;
      so_ff    <= nxt_so;
      ov_ff    <= nxt_ov;
    end
  end
  assign red_code               = o_col_ff[29:20];
  assign green_code             = o_col_ff[19:10];
  assign blue_code              = o_col_ff[9:0];
  assign red_level              = r_l_ff;
  assign green_level            = g_l_ff;
  assign blue_level             = b_l_ff;
  assign separate_sync_output_n = so_ff;
  assign pixel_valid            = ov_ff;

  // Strobe generator: pixel clock over 2, 4 or 8, high for first half
  logic [2:0] g_cnt_ff, nxt_g_cnt;
  logic       gen_ff, nxt_gen;
  always_comb begin
    nxt_g_cnt = (g_cnt_ff >= last_slot) ? 3'h0 : g_cnt_ff + 3'h1;
    nxt_gen   = (nxt_g_cnt <= (last_slot >> 1));
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      g_cnt_ff <= 3'h0;
      gen_ff   <= 1'b0;
    end else begin
      g_cnt_ff <= nxt_g_cnt;
      gen_ff   <= nxt_gen;
    end
  end
  assign generated_latch_strobe = gen_ff;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_capture;
    edge_det |=> (cap_ff == $past(s_bus[IN_W-2:0]));
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed data");

  property p_slot_order;
    edge_det ##1 !edge_det |=> (slot_ff == 3'h1) && act_ff;
  endproperty
  a_slot_order: assert property (p_slot_order) else $error("slot order wrong");

  property p_gen_2to1;
    (mux == MUX_2TO1) && $stable(mux) && gen_ff
      |=> !gen_ff ##1 (gen_ff || ($past(mux) != MUX_2TO1));
  endproperty
  a_gen_2to1: assert property (p_gen_2to1) else $error("strobe rate wrong");

  property p_shutdown;
    (fn == FN_PALETTE) && $stable(ctrl_ff) && (sel_ff != ctrl_ff[CTRL_MATCH +: 2])
      |-> ##2 (red_level == LVL_OFF) && (green_code == 10'h000);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown");

  property p_blank;
    // Tri-sync outranks blank on a channel that has it enabled
    !off_ff && c3_ff[1] && !c3_ff[0] && !(rse && tse && c3_ff[2]) |=> red_level == LVL_BLANK;
  endproperty
  a_blank: assert property (p_blank) else $error("blank not forced");

  property p_sync_ignored;
    !gse && !rse && !bse && $stable(ctrl_ff) |=> (green_level != LVL_SYNC)
      && (red_level != LVL_TRI);
  endproperty
  a_sync_ignored: assert property (p_sync_ignored) else $error("sync not ignored");

  property p_green_sync;
    gse && !tse && !off_ff && c3_ff[0] && $stable(ctrl_ff) |=> green_level == LVL_SYNC;
  endproperty
  a_green_sync: assert property (p_green_sync) else $error("green sync lost");

  property p_tri;
    rse && tse && !off_ff && c3_ff[2] && $stable(ctrl_ff) |=> red_level == LVL_TRI;
  endproperty
  a_tri: assert property (p_tri) else $error("tri-sync lost");

  property p_sep_sync;
    pv_ff && ctl_ff[0] |-> ##2 !separate_sync_output_n;
  endproperty
  a_sep_sync: assert property (p_sep_sync) else $error("sync out delay wrong");

  property p_overlay;
    (fn == FN_OVERLAY) && pv_ff && (sel_ff == 2'h3) && !ctl_ff[0] && $stable(ctrl_ff)
      && $stable(ovl_ff[2]) |-> ##2 ({red_code, green_code, blue_code} == ovl_ff[2]);
  endproperty
  a_overlay: assert property (p_overlay) else $error("overlay color wrong");

  c_eight: cover property (eight && edge_det ##[1:8] slot_ff == 3'h7);
  c_bypass: cover property (byp_ff && v3_ff);
  c_off: cover property (red_level == LVL_OFF);
  c_wb: cover property (wb_cyc_i && wb_stb_i && wb_we_i ##1 wb_ack_o);
endmodule

// file: mppi_fbuf_model.sv
`timescale 1ns/100ps
// Frame buffer side: one set of slot words per strobe, strobe still between frames
module mppi_fbuf_model import mppi_pkg::*; (
  output logic [DATA_W-1:0] color_data,
  output logic              sync_n,
  output logic              blank_n,
  output logic              three_level_sync_n,
  output logic [3:0]        priority_select_bit0,
  output logic [3:0]        priority_select_bit1,
  output logic              pixel_latch_strobe
);
  // Quiet lines at start, strobe low outside frames
  initial begin
    {color_data, priority_select_bit0, priority_select_bit1} = '0;
    {sync_n, blank_n, three_level_sync_n} = 3'h7;
    pixel_latch_strobe = 1'b0;
  end
  // Words settle well before the strobe edge; phase to mclk is left free
  task automatic send(input logic [DATA_W-1:0] d, input logic [3:0] s0,
                      input logic [3:0] s1, input logic [2:0] ctl);
    color_data = d;
    {priority_select_bit0, priority_select_bit1} = {s0, s1};
    {sync_n, blank_n, three_level_sync_n} = ctl;
    #31.25 pixel_latch_strobe = 1'b1;
    #62.5 pixel_latch_strobe = 1'b0;
    // Hold time over: show inverse words so a late sample cannot pass
    #31.25 color_data = ~d;
    {priority_select_bit0, priority_select_bit1} = ~{s0, s1};
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import mppi_pkg::*;
  logic mclk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0, priority_select_bit0, priority_select_bit1;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, sync_n, blank_n, three_level_sync_n, pixel_latch_strobe;
  logic generated_latch_strobe, separate_sync_output_n, pixel_valid;
  logic [DATA_W-1:0] color_data, words;
  logic [CODE_W-1:0] red_code, green_code, blue_code;
  mppi_level_t red_level, green_level, blue_level;
  logic [CODE_W-1:0] gr[8], gg[8], gb[8];
  mppi_level_t lr[8], lg[8], lb[8];
  logic gs[8];
  int n, fails = 0, total_checks = 0;
  // Pixel clock, 200 MHz
  always #2.5 mclk = ~mclk;
  mppi_port u_mppi_port(.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .color_data, .sync_n, .blank_n, .three_level_sync_n,
    .priority_select_bit0, .priority_select_bit1, .pixel_latch_strobe,
    .generated_latch_strobe, .separate_sync_output_n, .red_code, .green_code, .blue_code,
    .red_level, .green_level, .blue_level, .pixel_valid);
  mppi_fbuf_model u_mppi_fbuf_model(.color_data, .sync_n, .blank_n, .three_level_sync_n,
    .priority_select_bit0, .priority_select_bit1, .pixel_latch_strobe);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tmo(input string what);
    fails++;
    $display("[ERR] %0t timeout %s", $time, what);
    report_and_stop();
  endtask
  // Classic cycle: request held until the edge where ack is seen high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
    i = 0;
    do begin @(posedge mclk); i++; end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) tmo("bus");
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  function automatic logic [29:0] pal(input int i);
    return {10'(i + 1), 10'(i + 17), 10'(i + 33)};
  endfunction
  function automatic logic [29:0] ovl(input int j);
    return {10'(100 * j), 10'(100 * j + 1), 10'(100 * j + 2)};
  endfunction
  // Capture every emitted pixel of one strobe while the model sends it
  task automatic burst(input logic [31:0] c, input logic [3:0] s0, input logic [3:0] s1,
                       input logic [2:0] ctl);
    int i;
    wb(1, REG_CTRL, c);
    n = 0;
    fork
      u_mppi_fbuf_model.send(words, s0, s1, ctl);
      begin
        i = 0;
        do begin @(negedge mclk); i++; end while (pixel_valid !== 1'b1 && i < 60);
        if (i >= 60) tmo("pixel");
        while (pixel_valid === 1'b1 && n < 8) begin
          {gr[n], gg[n], gb[n], gs[n]} = {red_code, green_code, blue_code, separate_sync_output_n};
          {lr[n], lg[n], lb[n]} = {red_level, green_level, blue_level};
          n++;
          @(negedge mclk);
        end
      end
    join
  endtask
  task automatic px(input int k, input logic [29:0] e, input mppi_level_t l);
    chk(gr[k], e[29:20], "red");
    chk(gg[k], e[19:10], "green");
    chk(gb[k], e[9:0], "blue");
    chk(lr[k], l, "level");
  endtask
  // Setup: register defaults, unmapped place, palette and overlay colors
  task automatic sc_setup;
    wb(0, REG_CTRL, '0);
    chk(rd, CTRL_RST, "ctrl reset");
    wb(0, 8'h1C, '0);
    chk(rd, '0, "unmapped");
    wb(1, REG_PAL_ADDR, '0);
    for (int i = 0; i < 16; i++) wb(1, REG_PAL_DATA, {2'b00, pal(i)});
    for (int j = 1; j < 4; j++) wb(1, REG_OVL1 + 8'(4 * (j - 1)), {2'b00, ovl(j)});
  endtask
  // Each multiplex rate: strobe period, slot count and order, pseudo in 8:1
  task automatic sc_mux;
    int c, idx;
    for (int m = 0; m < 3; m++) begin
      burst(32'(m) | {22'h0, FN_IGNORE, 8'h00}, 4'h0, 4'h0, 3'h7);
      c = 0;
      do begin @(negedge mclk); c++; end while (generated_latch_strobe !== 1'b0 && c < 20);
      do begin @(negedge mclk); c++; end while (generated_latch_strobe !== 1'b1 && c < 20);
      if (c >= 20) tmo("out strobe");
      c = 0;
      do begin @(negedge mclk); c++; end while (generated_latch_strobe !== 1'b0 && c < 20);
      do begin @(negedge mclk); c++; end while (generated_latch_strobe !== 1'b1 && c < 20);
      if (c >= 20) tmo("out strobe");
      chk(c, 2 << m, "out strobe period");
      chk(n, 2 << m, "slot count");
      for (int j = 0; j < n; j++) begin
        idx = (m == 2) ? ((j % 2 == 0) ? j / 2 : j / 2 + 4) : 0;
        if (m == 2) px(j, {10'(idx + 1), 10'(idx + 17), 10'(idx + 33)}, LVL_VIDEO);
        else px(j, {10'(j + 1), 10'(j + 21), 10'(j + 41)}, LVL_VIDEO);
      end
    end
  endtask
  // Each select function with slot k carrying select value k
  task automatic sc_fn;
    logic [29:0] e;
    mppi_level_t l;
    for (int f = 0; f < 4; f++) begin
      burst(32'h0000_0801 | 32'(f << 8), 4'b1010, 4'b1100, 3'h7);
      chk(n, 4, "fn count");
      for (int k = 0; k < 4; k++) begin
        e = {10'(k + 1), 10'(k + 21), 10'(k + 41)};
        l = LVL_VIDEO;
        if (f == 0 && k != 2) begin e = '0; l = LVL_OFF; end
        if (f == 1 && k % 2 == 1) e = ovl(1);
        if (f == 1 && k == 2) e = {10'(k << 2), 10'((k + 4) << 2), 10'((k + 8) << 2)};
        if (f == 2 && k != 0) e = ovl(k);
        px(k, e, l);
      end
    end
  endtask
  // Sync, blank and three-level cases against the channel enables
  task automatic sc_sync;
    logic [31:0] c[4] = '{32'h10, 32'h0, 32'hE0, 32'h10};
    logic [2:0] ctl[4] = '{3'b011, 3'b011, 3'b110, 3'b101};
    mppi_level_t er[4] = '{LVL_VIDEO, LVL_VIDEO, LVL_TRI, LVL_BLANK};
    mppi_level_t eg[4] = '{LVL_SYNC, LVL_VIDEO, LVL_VIDEO, LVL_BLANK};
    logic es[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int r = 0; r < 4; r++) begin
      burst(32'h0000_0301 | c[r], 4'h0, 4'h0, ctl[r]);
      chk(n, 4, "sync count");
      for (int k = 0; k < n; k++) begin
        chk(lr[k], er[r], "red lvl");
        chk(lg[k], eg[r], "green lvl");
        chk(lb[k], er[r], "blue lvl");
        chk(gs[k], es[r], "sync out");
        if (er[r] != LVL_VIDEO) chk(gr[k], 10'(k + 1), "red code");
      end
    end
  endtask
  // 8:1 pseudo: odd pixels take selects from the blue byte, bypass not offered
  task automatic sc_eight;
    logic [29:0] e;
    int idx;
    for (int f = 1; f < 3; f++) begin
      burst(32'h0000_0002 | 32'(f << 8), 4'b1010, 4'b1100, 3'h7);
      chk(n, 8, "eight count");
      for (int j = 0; j < 8; j++) begin
        idx = (j % 2 == 0) ? j / 2 : j / 2 + 4;
        e = (f == 2 && j / 2 != 0) ? ovl(j / 2) : pal(idx);
        px(j, e, LVL_VIDEO);
      end
    end
  endtask
  initial begin
    words = '0;
    for (int k = 0; k < 4; k++) words[24 * k +: 24] = {8'(k), 8'(k + 4), 8'(k + 8)};
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    sc_setup();
    sc_mux();
    sc_fn();
    sc_eight();
    sc_sync();
    report_and_stop();
  end
endmodule
